// ==== verilog/cmcs_pkg.sv ====
/*
 * Shared constants for the translation and cache subsystem: register
 * offsets, control and descriptor field positions, reset values and the
 * per-unit state encoding.
 * Assumes a 32-bit AHB-Lite register bus and one core clock.
 */
package cmcs_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_DAC   = 8'h04;
    localparam logic [7:0] REG_TTB   = 8'h08;
    localparam logic [7:0] REG_ILOCK = 8'h0c;
    localparam logic [7:0] REG_DLOCK = 8'h10;
    localparam logic [7:0] REG_CLOCK = 8'h14;
    localparam logic [7:0] REG_STAT  = 8'h18;
    // Control register bits
    localparam int CTL_MMU = 0;
    localparam int CTL_IC  = 1;
    localparam int CTL_DC  = 2;
    localparam int CTL_MRA = 3;
    localparam int CTL_MWA = 4;
    localparam int CTL_MWB = 5;
    // Cache lock register fields
    localparam int CLK_IC   = 0;
    localparam int CLK_DC   = 8;
    localparam int CLK_SRAM = 16;
    // Descriptor fields: [31:12] frame, [11:8] domain, [7:6] access, [4:0] attributes
    localparam int DSC_DOM = 8;
    localparam int DSC_AP  = 6;
    localparam int ATR_C   = 0;
    localparam int ATR_B   = 1;
    localparam int ATR_RA  = 2;
    localparam int ATR_WA  = 3;
    localparam int ATR_MIN = 4;
    // Reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_DAC  = 32'h0000_0000;
    localparam logic [31:0] RST_TTB  = 32'h0000_0000;
    localparam logic [31:0] RST_LOCK = 32'h0000_0000;
    // Largest lockable way count per cache set
    localparam logic [5:0] LOCK_MAX = 6'h1c;
    // Entries that can be locked; entry 31 never
    localparam logic [31:0] TLB_LOCKABLE = 32'h7fff_ffff;
    localparam logic [2:0] LAST_WORD = 3'h7;

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_LOOK  = 7'h02,
        S_WALK  = 7'h04,
        S_CACHE = 7'h08,
        S_WB    = 7'h10,
        S_FILL  = 7'h20,
        S_DONE  = 7'h40
    } cmcs_state_t;
endpackage

// ==== verilog/cmcs_top.sv ====
/*
 * Instruction and data translation units with their lookaside buffers,
 * table walks and domain checks, plus tag state of the instruction cache,
 * data cache and mini data cache (valid, dirty, lock, round-robin).
 * Assumes the core and the memory controller run on hclk and hold each
 * request until answered; registers are reached over AHB-Lite.
 */
`timescale 1ns/1ns
// Summary of operation
// - Instruction buffer: 32 entries, round-robin victims
// - Instruction entries 0-30 lockable, 31 never
// - Instruction miss walks table, loads, then completes
// - Sixteen domains; instruction violation gives prefetch abort
// - Data buffer: 32 entries, round-robin, 0-30 lockable
// - Data miss walks table, inserts, then continues
// - Data domain violation cancels access, data abort
// - One enable for both translation units
// - Instruction cache 32 sets by 32 ways
// - Up to 28 instruction ways locked; round-robin rest
// - Line fill critical word first, queued fetch
// - Instruction cache enable; descriptor attributes govern caching
// - Data cache 32x32, two dirty bits, valid
// - Data ways locked, unlocked or local RAM
// - Descriptor attributes pick allocate, write policy, target
// - One enable for both data caches
// - Data caches serve one access at a time; no hit while a data miss is outstanding
// - Stores to memory go through write buffer
// - Mini cache 32 sets by two ways
// - Mini cache round-robin, never locked
// - Mini cache policies from control register bits
module cmcs_top #(
    parameter int IC_WAYS   = 32,
    parameter int DC_WAYS   = 32,
    parameter int MINI_WAYS = 2
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic [1:0]        core_req,
    input  wire logic [1:0]        core_write,
    input  wire logic [1:0][31:0]  core_vaddr,
    output logic [1:0]             core_ack,
    output logic [1:0]             core_abort,
    output logic [1:0]             core_hit,
    output logic [1:0][31:0]       core_paddr,
    output logic [1:0][31:0]       core_rdata,
    output logic [1:0]             mem_req,
    output logic [1:0]             mem_walk,
    output logic [1:0][31:0]       mem_addr,
    input  wire logic [1:0]        mem_ack,
    input  wire logic [1:0][31:0]  mem_rdata,
    output logic [1:0]             wb_valid,
    output logic [1:0][31:0]       wb_addr,
    input  wire logic [1:0]        wb_ready
);
    // Refuse shapes the 5-bit way index cannot serve, and caches with no way above the 28 lockable
    if (IC_WAYS > 32 || DC_WAYS > 32 || MINI_WAYS > 32 || MINI_WAYS < 1 ||
        IC_WAYS <= 28 || DC_WAYS <= 28) begin : g_bad
        $error("cmcs_top: unsupported way count");
    end

    logic [31:0]         ctrl;
    logic [31:0]         dac;
    logic [31:0]         ttb;
    logic [1:0][31:0]    tlock;
    logic [31:0]         clock_r;
    logic                ap_wr;
    logic [7:0]          ap_addr;
    logic [31:0]         tlb_v [2];
    logic [19:0]         tlb_tag [2][32];
    logic [31:0]         tlb_desc [2][32];
    logic [4:0]          tlb_rr [2];
    logic [31:0]         c_val [3][32];
    logic [21:0]         c_tag [3][32][32];
    logic [1:0]          c_dirty [3][32][32];
    logic [4:0]          c_rr [3][32];
    cmcs_pkg::cmcs_state_t st [2];
    logic [31:0]         va [2];
    logic [31:0]         desc [2];
    logic [1:0]          wr;
    logic [1:0]          abt;
    logic [1:0]          alloc;
    logic [4:0]          vic [2];
    logic [2:0]          cnt [2];
    logic [31:0]         wba [2];
    cmcs_pkg::cmcs_state_t after_wb [2];
    logic [1:0]          thit;
    logic [4:0]          tidx [2];
    logic [4:0]          tvic [2];
    logic [1:0]          viol;
    logic [1:0]          ci [2];
    logic [4:0]          cset [2];
    logic [1:0]          chit;
    logic [4:0]          cway [2];
    logic [4:0]          cvic [2];
    logic [1:0]          cuse;
    logic [1:0]          c_wb;
    logic [1:0]          c_ra;
    logic [1:0]          c_wa;
    logic [1:0]          vdirty;
    logic [1:0]          tlb_wr;
    logic [1:0]          c_inst;
    logic [1:0]          c_mark;
    logic [5:0]          ic_lock;
    logic [5:0]          dc_lock;
    logic [5:0]          dc_sram;
    logic [5:0]          dc_wlock;
    logic                mmu_en;

    // First free unlocked way, else next unlocked way from the pointer
    function automatic logic [4:0] pick(input logic [31:0] v, input logic [31:0] lk,
                                        input logic [4:0] rr);
        logic [4:0] r;
        logic       f;
        logic [4:0] k;
        r = rr;
        f = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (!f && !v[i] && !lk[i]) begin
                r = 5'(i);
                f = 1'b1;
            end
        end
        for (int i = 0; i < 32; i++) begin
            k = 5'(rr + 5'(i));
            if (!f && !lk[k]) begin
                r = k;
                f = 1'b1;
            end
        end
        return r;
    endfunction

    // Ways below lo are locked, ways at or above hi do not exist
    function automatic logic [31:0] wmask(input logic [5:0] lo, input int hi);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            m[i] = (6'(i) < lo) || (i >= hi);
        end
        return m;
    endfunction

    assign mmu_en  = ctrl[cmcs_pkg::CTL_MMU];
    assign ic_lock = clock_r[cmcs_pkg::CLK_IC +: 6];
    assign dc_lock = clock_r[cmcs_pkg::CLK_DC +: 6];
    assign dc_sram = clock_r[cmcs_pkg::CLK_SRAM +: 6];
    // Clamped data lock count being written; local RAM never exceeds it
    assign dc_wlock = (hwdata[13:8] > cmcs_pkg::LOCK_MAX) ? cmcs_pkg::LOCK_MAX : hwdata[13:8];

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr   <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_wr   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            ap_addr <= haddr[7:0];
        end
    end

    // Register writes in the data phase; lock counts clamp to 28
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl    <= cmcs_pkg::RST_CTRL;
            dac     <= cmcs_pkg::RST_DAC;
            ttb     <= cmcs_pkg::RST_TTB;
            tlock   <= {cmcs_pkg::RST_LOCK, cmcs_pkg::RST_LOCK};
            clock_r <= cmcs_pkg::RST_LOCK;
        end else if (ap_wr) begin
            unique case (ap_addr)
                cmcs_pkg::REG_CTRL:  ctrl <= {26'h0, hwdata[5:0]};
                cmcs_pkg::REG_DAC:   dac <= hwdata;
                cmcs_pkg::REG_TTB:   ttb <= {hwdata[31:2], 2'h0};
                cmcs_pkg::REG_ILOCK: tlock[0] <= hwdata & cmcs_pkg::TLB_LOCKABLE;
                cmcs_pkg::REG_DLOCK: tlock[1] <= hwdata & cmcs_pkg::TLB_LOCKABLE;
                cmcs_pkg::REG_CLOCK: begin
                    clock_r <= '0;
                    clock_r[cmcs_pkg::CLK_IC +: 6] <= (hwdata[5:0] > cmcs_pkg::LOCK_MAX) ?
                        cmcs_pkg::LOCK_MAX : hwdata[5:0];
                    clock_r[cmcs_pkg::CLK_DC +: 6] <= dc_wlock;
                    clock_r[cmcs_pkg::CLK_SRAM +: 6] <= (hwdata[21:16] > dc_wlock) ?
                        dc_wlock : hwdata[21:16];
                end
                default: ;
            endcase
        end
    end

    // Read data, registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready) begin
            hrdata <= 32'h0;
            if (hsel && htrans[1] && !hwrite) begin
                unique case (haddr[7:0])
                    cmcs_pkg::REG_CTRL:  hrdata <= ctrl;
                    cmcs_pkg::REG_DAC:   hrdata <= dac;
                    cmcs_pkg::REG_TTB:   hrdata <= ttb;
                    cmcs_pkg::REG_ILOCK: hrdata <= tlock[0];
                    cmcs_pkg::REG_DLOCK: hrdata <= tlock[1];
                    cmcs_pkg::REG_CLOCK: hrdata <= clock_r;
                    cmcs_pkg::REG_STAT:  hrdata <= {6'h0, tlb_rr[1], tlb_rr[0], 1'b0, st[1],
                                                    1'b0, st[0]};
                    default:             hrdata <= 32'h0;
                endcase
            end
        end
    end

    // Translation lookup, domain check and cache lookup per unit
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            thit[u] = 1'b0;
            tidx[u] = 5'h0;
            for (int i = 0; i < 32; i++) begin
                if (tlb_v[u][i] && tlb_tag[u][i] == va[u][31:12]) begin
                    thit[u] = 1'b1;
                    tidx[u] = 5'(i);
                end
            end
            tvic[u] = pick(tlb_v[u], tlock[u], tlb_rr[u]);
            // Domain 00/10 denies, 01 checks access bits, 11 grants
            viol[u] = 1'b0;
            unique case (dac[2 * tlb_desc[u][tidx[u]][cmcs_pkg::DSC_DOM +: 4] +: 2])
                2'h1: viol[u] = tlb_desc[u][tidx[u]][cmcs_pkg::DSC_AP +: 2] == 2'h0 ||
                                (wr[u] && tlb_desc[u][tidx[u]][cmcs_pkg::DSC_AP +: 2] == 2'h1);
                2'h3: viol[u] = 1'b0;
                default: viol[u] = 1'b1;
            endcase
            ci[u]   = (u == 1 && desc[u][cmcs_pkg::ATR_MIN]) ? 2'h2 : 2'(u);
            cset[u] = va[u][9:5];
            cuse[u] = desc[u][cmcs_pkg::ATR_C] &&
                      ctrl[u == 0 ? cmcs_pkg::CTL_IC : cmcs_pkg::CTL_DC];
            c_wb[u] = ci[u] == 2'h2 ? ctrl[cmcs_pkg::CTL_MWB] : desc[u][cmcs_pkg::ATR_B];
            c_ra[u] = ci[u] == 2'h2 ? ctrl[cmcs_pkg::CTL_MRA] : desc[u][cmcs_pkg::ATR_RA];
            c_wa[u] = ci[u] == 2'h2 ? ctrl[cmcs_pkg::CTL_MWA] : desc[u][cmcs_pkg::ATR_WA];
            chit[u] = 1'b0;
            cway[u] = 5'h0;
            for (int w = 0; w < 32; w++) begin
                if (c_val[ci[u]][cset[u]][w] && c_tag[ci[u]][cset[u]][w] == va[u][31:10] &&
                    !(ci[u] == 2'h1 && 6'(w) < dc_sram)) begin
                    chit[u] = 1'b1;
                    cway[u] = 5'(w);
                end
            end
            unique case (ci[u])
                2'h0: cvic[u] = pick(c_val[0][cset[u]], wmask(ic_lock, IC_WAYS),
                                     c_rr[0][cset[u]]);
                2'h1: cvic[u] = pick(c_val[1][cset[u]], wmask(dc_lock, DC_WAYS),
                                     c_rr[1][cset[u]]);
                default: cvic[u] = pick(c_val[2][cset[u]], wmask(6'h0, MINI_WAYS),
                                        c_rr[2][cset[u]]);
            endcase
            vdirty[u] = c_val[ci[u]][cset[u]][cvic[u]] && |c_dirty[ci[u]][cset[u]][cvic[u]];
            tlb_wr[u] = st[u] == cmcs_pkg::S_WALK && mem_ack[u];
            c_inst[u] = st[u] == cmcs_pkg::S_FILL && mem_ack[u] && alloc[u] &&
                        cnt[u] == cmcs_pkg::LAST_WORD;
            c_mark[u] = st[u] == cmcs_pkg::S_CACHE && cuse[u] && chit[u] && wr[u] && c_wb[u];
            core_ack[u]   = st[u] == cmcs_pkg::S_DONE && !abt[u];
            core_abort[u] = st[u] == cmcs_pkg::S_DONE && abt[u];
            mem_req[u]    = st[u] == cmcs_pkg::S_WALK || st[u] == cmcs_pkg::S_FILL;
            mem_walk[u]   = st[u] == cmcs_pkg::S_WALK;
            mem_addr[u]   = st[u] == cmcs_pkg::S_WALK ? 32'(ttb + {va[u][31:12], 2'h0}) :
                            {core_paddr[u][31:5], 3'(core_paddr[u][4:2] + cnt[u]), 2'h0};
            wb_valid[u]   = st[u] == cmcs_pkg::S_WB;
            wb_addr[u]    = wba[u];
        end
    end

    // Per-unit sequencing; each unit runs alone so one may hit while the other misses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int u = 0; u < 2; u++) begin
                st[u]       <= cmcs_pkg::S_IDLE;
                va[u]       <= 32'h0;
                desc[u]     <= 32'h0;
                vic[u]      <= 5'h0;
                cnt[u]      <= 3'h0;
                wba[u]      <= 32'h0;
                after_wb[u] <= cmcs_pkg::S_DONE;
            end
            wr         <= 2'h0;
            abt        <= 2'h0;
            alloc      <= 2'h0;
            core_hit   <= 2'h0;
            core_paddr <= '0;
            core_rdata <= '0;
        end else begin
            for (int u = 0; u < 2; u++) begin
                unique case (st[u])
                    cmcs_pkg::S_IDLE: if (core_req[u]) begin
                        va[u]    <= core_vaddr[u];
                        wr[u]    <= u == 1 && core_write[u];
                        abt[u]   <= 1'b0;
                        core_hit[u] <= 1'b0;
                        st[u]    <= cmcs_pkg::S_LOOK;
                    end
                    cmcs_pkg::S_LOOK: begin
                        if (!mmu_en) begin
                            desc[u]       <= 32'h0;
                            core_paddr[u] <= va[u];
                            st[u]         <= cmcs_pkg::S_CACHE;
                        end else if (!thit[u]) begin
                            vic[u] <= tvic[u];
                            st[u]  <= cmcs_pkg::S_WALK;
                        end else if (viol[u]) begin
                            abt[u] <= 1'b1;
                            st[u]  <= cmcs_pkg::S_DONE;
                        end else begin
                            desc[u]       <= tlb_desc[u][tidx[u]];
                            core_paddr[u] <= {tlb_desc[u][tidx[u]][31:12], va[u][11:0]};
                            st[u]         <= cmcs_pkg::S_CACHE;
                        end
                    end
                    cmcs_pkg::S_WALK: if (mem_ack[u]) begin
                        st[u] <= cmcs_pkg::S_LOOK;
                    end
                    cmcs_pkg::S_CACHE: begin
                        cnt[u] <= 3'h0;
                        wba[u] <= core_paddr[u];
                        after_wb[u] <= cmcs_pkg::S_DONE;
                        if (cuse[u] && chit[u]) begin
                            core_hit[u] <= 1'b1;
                            st[u] <= (wr[u] && !c_wb[u]) ? cmcs_pkg::S_WB : cmcs_pkg::S_DONE;
                        end else if (cuse[u] && (wr[u] ? c_wa[u] : c_ra[u])) begin
                            alloc[u] <= 1'b1;
                            vic[u]   <= cvic[u];
                            wba[u]   <= {c_tag[ci[u]][cset[u]][cvic[u]], cset[u], 5'h0};
                            after_wb[u] <= cmcs_pkg::S_FILL;
                            st[u] <= vdirty[u] ? cmcs_pkg::S_WB : cmcs_pkg::S_FILL;
                        end else begin
                            alloc[u] <= 1'b0;
                            st[u] <= wr[u] ? cmcs_pkg::S_WB : cmcs_pkg::S_FILL;
                        end
                    end
                    cmcs_pkg::S_WB: if (wb_ready[u]) begin
                        st[u] <= after_wb[u];
                    end
                    cmcs_pkg::S_FILL: if (mem_ack[u]) begin
                        if (cnt[u] == 3'h0 && !wr[u]) begin
                            core_rdata[u] <= mem_rdata[u];
                        end
                        cnt[u] <= 3'(cnt[u] + 3'h1);
                        if (!alloc[u] || cnt[u] == cmcs_pkg::LAST_WORD) begin
                            wba[u]      <= core_paddr[u];
                            after_wb[u] <= cmcs_pkg::S_DONE;
                            st[u] <= (alloc[u] && wr[u] && !c_wb[u]) ? cmcs_pkg::S_WB :
                                     cmcs_pkg::S_DONE;
                        end
                    end
                    cmcs_pkg::S_DONE: st[u] <= cmcs_pkg::S_IDLE;
                    default: st[u] <= cmcs_pkg::S_IDLE;
                endcase
            end
        end
    end

    // Valid bits and round-robin pointers move only when something is installed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tlb_v  <= '{default: 32'h0};
            tlb_rr <= '{default: 5'h0};
            c_val  <= '{default: '{default: 32'h0}};
            c_rr   <= '{default: '{default: 5'h0}};
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (tlb_wr[u]) begin
                    tlb_v[u][vic[u]] <= 1'b1;
                    tlb_rr[u]        <= 5'(vic[u] + 5'h1);
                end
                if (c_inst[u]) begin
                    c_val[ci[u]][cset[u]][vic[u]] <= 1'b1;
                    c_rr[ci[u]][cset[u]]          <= 5'(vic[u] + 5'h1);
                end
            end
        end
    end

    // Entry contents: descriptor, tag and dirty halves
    always_ff @(posedge hclk) begin
        for (int u = 0; u < 2; u++) begin
            if (tlb_wr[u]) begin
                tlb_tag[u][vic[u]]  <= va[u][31:12];
                tlb_desc[u][vic[u]] <= mem_rdata[u];
            end
            if (c_inst[u]) begin
                c_tag[ci[u]][cset[u]][vic[u]]   <= va[u][31:10];
                c_dirty[ci[u]][cset[u]][vic[u]] <= (wr[u] && c_wb[u]) ?
                                                   (2'h1 << va[u][4]) : 2'h0;
            end
            if (c_mark[u]) begin
                c_dirty[ci[u]][cset[u]][cway[u]][va[u][4]] <= 1'b1;
            end
        end
    end

    ilock_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tlb_wr[0] |-> !tlock[0][vic[0]]) else $error("locked entry replaced");
    dlock_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tlb_wr[1] |-> !tlock[1][vic[1]]) else $error("locked entry replaced");
    iwalk_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tlb_wr[0] |=> st[0] == cmcs_pkg::S_LOOK && thit[0]) else $error("no reload");
    dwalk_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tlb_wr[1] |=> st[1] == cmcs_pkg::S_LOOK && thit[1]) else $error("no reload");
    iperm_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st[0] == cmcs_pkg::S_LOOK && mmu_en && thit[0] && viol[0])
        |=> core_abort[0] ##1 st[0] == cmcs_pkg::S_IDLE) else $error("no abort");
    dperm_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
        core_abort[1] |-> mmu_en && !mem_req[1] && $past(st[1]) == cmcs_pkg::S_LOOK)
        else $error("bad abort");
    ic_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_inst[0]) |-> 6'(vic[0]) >= ic_lock) else $error("locked way filled");
    mini_way_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (c_inst[1] && ci[1] == 2'h2) |-> 32'(vic[1]) < MINI_WAYS) else $error("bad way");
    rr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !tlb_wr[0] |=> $stable(tlb_rr[0])) else $error("pointer moved");
endmodule

// ==== verification/cmcs_mem_model.sv ====
/* Memory and write-buffer model for the far side of cmcs_top.
   Assumes the design holds mem_req and wb_valid until answered. */
`timescale 1ns/1ns
module cmcs_mem_model #(
    parameter logic [31:0] DESC = 32'h1234_50c5 // Domain 0, read-write, cacheable, read-allocate
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [1:0]       mem_req,
    input  wire logic [1:0]       mem_walk,
    input  wire logic [1:0][31:0] mem_addr,
    output logic [1:0]            mem_ack,
    output logic [1:0][31:0]      mem_rdata,
    output logic [1:0]            wb_ready
);
    // Ack every other cycle; read data is the inverted address, or DESC on a walk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 2'h0;
            mem_rdata <= '0;
            wb_ready <= 2'h0;
        end else begin
            for (int u = 0; u < 2; u++) begin
                mem_ack[u] <= mem_req[u] & ~mem_ack[u];
                mem_rdata[u] <= mem_walk[u] ? DESC : ~mem_addr[u];
                wb_ready[u] <= ~wb_ready[u]; // Stall half the time
            end
        end
    end
endmodule

// ==== verification/cmcs_top_tb_top.sv ====
/* Directed bench for cmcs_top: registers, locks, flat access, walk, cache hits, aborts.
   Assumes zero-wait AHB slave and the memory model beside it. */
`timescale 1ns/1ns
module cmcs_top_tb_top;
    logic hclk, hresetn, hwrite, hrdy, hro, hresp;
    logic [1:0] htrans, core_req, core_write, ack, abort, hit, mreq, mwalk, mack, wbv, wbr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0][31:0] core_vaddr, paddr, crd, maddr, mrd, wba;
    int mismatches = 0, check_count = 0;
    assign hrdy = hro;
    cmcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hro),
        .hresp(hresp), .hrdata(hrdata), .core_req(core_req), .core_write(core_write),
        .core_vaddr(core_vaddr), .core_ack(ack), .core_abort(abort), .core_hit(hit),
        .core_paddr(paddr), .core_rdata(crd), .mem_req(mreq), .mem_walk(mwalk),
        .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mrd), .wb_valid(wbv), .wb_addr(wba),
        .wb_ready(wbr));
    cmcs_mem_model MEM (.hclk(hclk), .hresetn(hresetn), .mem_req(mreq), .mem_walk(mwalk),
        .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mrd), .wb_ready(wbr));
    // Clock generator
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB word transfer; read data taken at the data-phase edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge hclk); while (hro !== 1'b1);
        htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hro !== 1'b1);
        rd = hrdata;
        chk({30'h0, hro, hresp}, 32'h2);
    endtask
    // One core read on unit u; expects abort ab, cache hit ht, address pa; bounded wait
    task automatic core(input int u, input logic [31:0] va, input logic ab, input logic ht,
                        input logic [31:0] pa);
        int n;
        n = 0;
        core_req[u] <= 1'b1; core_write[u] <= 1'b0; core_vaddr[u] <= va;
        do begin @(negedge hclk); n++; end while (ack[u] !== 1'b1 && abort[u] !== 1'b1 && n < 300);
        chk({31'h0, ack[u] | abort[u]}, 32'h1);
        chk({31'h0, abort[u]}, {31'h0, ab});
        if (!ab) chk(paddr[u], pa);
        if (!ab) chk({31'h0, hit[u]}, {31'h0, ht});
        if (!ab && !ht) chk(crd[u], ~{pa[31:2], 2'h0});
        @(posedge hclk);
        core_req[u] <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        hresetn = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = '0; hwdata = '0;
        core_req = 2'h0; core_write = 2'h0; core_vaddr = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, cmcs_pkg::REG_CTRL, 32'h0); chk(rd, cmcs_pkg::RST_CTRL);
        ahb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
        ahb(1'b1, cmcs_pkg::REG_ILOCK, 32'hffff_ffff);
        ahb(1'b0, cmcs_pkg::REG_ILOCK, 32'h0); chk(rd, 32'h7fff_ffff);
        ahb(1'b1, cmcs_pkg::REG_CLOCK, 32'h003e_3f3f);
        ahb(1'b0, cmcs_pkg::REG_CLOCK, 32'h0); chk(rd, 32'h001c_1c1c);
        $display("test registers done");
        core(1, 32'h0000_1234, 1'b0, 1'b0, 32'h0000_1234);
        core(0, 32'h0000_1234, 1'b0, 1'b0, 32'h0000_1234);
        $display("test flat done");
        ahb(1'b1, cmcs_pkg::REG_DAC, 32'h3);
        ahb(1'b1, cmcs_pkg::REG_CTRL, 32'h7);
        core(0, 32'h0000_5678, 1'b0, 1'b0, 32'h1234_5678);
        core(1, 32'h0000_5abc, 1'b0, 1'b0, 32'h1234_5abc);
        core(0, 32'h0000_5004, 1'b0, 1'b0, 32'h1234_5004);
        core(0, 32'h0000_567c, 1'b0, 1'b1, 32'h1234_567c);
        core(1, 32'h0000_5ab0, 1'b0, 1'b1, 32'h1234_5ab0);
        $display("test walk done");
        ahb(1'b1, cmcs_pkg::REG_DAC, 32'h0);
        core(1, 32'h0000_5aaa, 1'b1, 1'b0, 32'h0);
        core(0, 32'h0000_5aaa, 1'b1, 1'b0, 32'h0);
        $display("test abort done");
        results();
    end
    // Watchdog
    initial begin
        #3000000;
        mismatches++;
        results();
    end
endmodule
